// ### logic/bit_push_if.sv
`timescale 1ns/1ps
interface bit_push_if;
	logic valid;
	logic ready;
	logic data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

// ### logic/crc8_serial.sv
`timescale 1ns/1ps
module crc8_serial
	import rom_id_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clear,
	input wire logic shift,
	input wire logic din,
	output logic [7:0] crc,
	output logic zero_next
);
	logic [7:0] crc_r;
	logic [7:0] crc_nxt;

	always_comb
	begin
		crc_nxt = crc_r;
		if (clear)
			crc_nxt = CRC_INIT;
		else if (shift)
			crc_nxt = crc8_step(crc_r, din);
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			crc_r <= CRC_INIT;
		else
			crc_r <= crc_nxt;
	end

	assign crc = crc_r;
	assign zero_next = (crc8_step(crc_r, din) == 8'h00);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_crc_clear_zero: assert property (clear |=> crc_r == 8'h00)
		else $error("check register not cleared");
	chk_crc_hold_idle: assert property (!clear && !shift |=> $stable(crc_r))
		else $error("check register moved without a shift");
endmodule

// ### logic/pair_buffer.sv
`timescale 1ns/1ps
module pair_buffer #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic reset,
	bit_push_if.sink in_port,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_port.ready = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_port.valid && in_port.ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		if (push)
		begin
			mem_nxt[wr_r] = WIDTH'(in_port.data);
			wr_nxt = (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
		end
		if (pop)
			rd_nxt = (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
		end
		else
		begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			mem_r <= mem_nxt;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_buf_no_overrun: assert property (cnt_r == (PW+1)'(DEPTH) |-> !in_port.ready)
		else $error("buffer accepted while full");
	chk_buf_hold_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("stalled word changed or lost");
endmodule

// ### logic/rom_id_pkg.sv
package rom_id_pkg;

	// ------------------------------------------------------------
	// Code layout
	// ------------------------------------------------------------
	localparam int ID_BITS = 64;
	localparam int PREFIX_BITS = 56;
	localparam int FAMILY_W = 8;
	localparam int SERIAL_W = 36;
	localparam int RANGE_W = 12;
	localparam int CHECK_W = 8;
	localparam int BYTE_W = 8;
	localparam int FAMILY_LSB = 0;
	localparam int SERIAL_LSB = 8;
	localparam int RANGE_LSB = 44;
	localparam int CHECK_LSB = 56;
	localparam logic [6:0] LAST_ID_BIT = 7'h3f;
	localparam logic [6:0] LAST_BYTE_BIT = 7'h07;

	// ------------------------------------------------------------
	// Check generator, x^8 + x^5 + x^4 + 1, shifted LSB first
	// ------------------------------------------------------------
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [7:0] CRC_POLY_REFL = 8'h8c;

	// ------------------------------------------------------------
	// Address-level command bytes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ID = 8'h01;
	localparam logic [7:0] CMD_MATCH_ID = 8'h02;
	localparam logic [7:0] CMD_SEARCH_ID = 8'h03;
	localparam logic [7:0] CMD_COND_SEARCH = 8'h04;
	localparam logic [7:0] CMD_SKIP_ID = 8'h05;
	localparam logic [7:0] CMD_FAST_SKIP = 8'h06;
	localparam logic [7:0] CMD_FAST_MATCH = 8'h07;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR_CMD, ST_READ, ST_MATCH, ST_SRCH_TRUE,
		ST_SRCH_COMP, ST_SRCH_DIR, ST_MEM_CMD, ST_DONE, ST_DROP
	} link_state_e;

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic din);
		logic fb;
		fb = din ^ crc[0];
		crc8_step = (crc >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
	endfunction

	function automatic logic [7:0] crc8_of_prefix(input logic [PREFIX_BITS-1:0] prefix);
		logic [7:0] crc;
		crc = CRC_INIT;
		for (int i = 0; i < PREFIX_BITS; i++)
			crc = crc8_step(crc, prefix[i]);
		crc8_of_prefix = crc;
	endfunction

endpackage

// ### logic/rom_identity_crc_access.sv
`timescale 1ns/1ps
module rom_identity_crc_access
	import rom_id_pkg::*;
#(
	parameter logic [FAMILY_W-1:0] FAMILY_CODE = 8'h5a, // Arbitrary value
	parameter logic [SERIAL_W-1:0] SERIAL_NUM = 36'h012345678, // Arbitrary value
	parameter logic [RANGE_W-1:0] RANGE_CODE = 12'h0a5 // Arbitrary value
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic link_reset,
	input wire logic speed_reset,
	input wire logic rx_valid,
	input wire logic rx_bit,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic tx_bit,
	input wire logic alarm_cond,
	output logic fast_mode,
	output logic addr_ok,
	output logic id_check_ok,
	output logic mem_cmd_valid,
	output logic [7:0] mem_cmd
);
	import rom_id_pkg::*;

	// ------------------------------------------------------------
	// Identity code
	// ------------------------------------------------------------
	localparam logic [PREFIX_BITS-1:0] ID_PREFIX = {RANGE_CODE, SERIAL_NUM, FAMILY_CODE};
	localparam logic [CHECK_W-1:0] ID_CHECK = crc8_of_prefix(ID_PREFIX);
	localparam logic [ID_BITS-1:0] ID_CODE = {ID_CHECK, ID_PREFIX};

	// ------------------------------------------------------------
	// Link state
	// ------------------------------------------------------------
	link_state_e state_r, state_nxt;
	logic [6:0] cnt_r, cnt_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic fast_r, fast_nxt;
	logic addr_ok_r, addr_ok_nxt;
	logic match_r, match_nxt;
	logic id_ok_r, id_ok_nxt;
	logic mem_v_r, mem_v_nxt;
	logic [7:0] mem_cmd_r, mem_cmd_nxt;

	logic [7:0] rx_byte;
	logic id_bit;
	logic crc_clear, crc_shift, crc_zero_next;
	logic [7:0] crc_val;
	logic buf_flush;

	bit_push_if push_if ();

	assign rx_byte = {rx_bit, byte_r[7:1]};
	assign id_bit = ID_CODE[cnt_r[5:0]];

	// ------------------------------------------------------------
	// Check generator for received codes
	// ------------------------------------------------------------
	// Cleared on each link reset so a match always starts from zero
	assign crc_clear = link_reset;
	assign crc_shift = (state_r == ST_MATCH) && rx_valid && !link_reset;

	crc8_serial u_crc (
		.clk_sys(clk_sys),
		.reset(reset),
		.clear(crc_clear),
		.shift(crc_shift),
		.din(rx_bit),
		.crc(crc_val),
		.zero_next(crc_zero_next)
	);

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------
	// Two entries hold both search bits so a slow slot layer loses none
	// A link reset aborts any send, so stale code bits never leak out
	assign buf_flush = reset || link_reset;
	always_comb
	begin
		push_if.valid = 1'b0;
		push_if.data = 1'b0;
		case (state_r)
			ST_READ, ST_SRCH_TRUE:
			begin
				push_if.valid = 1'b1;
				push_if.data = id_bit;
			end
			ST_SRCH_COMP:
			begin
				push_if.valid = 1'b1;
				push_if.data = ~id_bit;
			end
			default:
			begin
				push_if.valid = 1'b0;
				push_if.data = 1'b0;
			end
		endcase
	end

	pair_buffer #(
		.WIDTH(1),
		.DEPTH(2)
	) u_tx_buf (
		.clk_sys(clk_sys),
		.reset(buf_flush),
		.in_port(push_if.sink),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_bit)
	);

	// ------------------------------------------------------------
	// Command sequencing
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		byte_nxt = byte_r;
		fast_nxt = fast_r;
		addr_ok_nxt = addr_ok_r;
		match_nxt = match_r;
		id_ok_nxt = id_ok_r;
		mem_v_nxt = 1'b0;
		mem_cmd_nxt = mem_cmd_r;
		if (speed_reset)
			fast_nxt = 1'b0;
		if (link_reset)
		begin
			// Every link reset demands a fresh address command
			state_nxt = ST_ADDR_CMD;
			cnt_nxt = '0;
			byte_nxt = '0;
			addr_ok_nxt = 1'b0;
			match_nxt = 1'b1;
			id_ok_nxt = 1'b0;
		end
		else
		begin
			case (state_r)
				ST_ADDR_CMD:
					if (rx_valid)
					begin
						byte_nxt = rx_byte;
						cnt_nxt = cnt_r + 7'h01;
						if (cnt_r == LAST_BYTE_BIT)
						begin
							cnt_nxt = '0;
							case (rx_byte)
								CMD_READ_ID: state_nxt = ST_READ;
								CMD_MATCH_ID: state_nxt = ST_MATCH;
								CMD_SEARCH_ID: state_nxt = ST_SRCH_TRUE;
								CMD_COND_SEARCH:
									state_nxt = alarm_cond ? ST_SRCH_TRUE : ST_DROP;
								CMD_SKIP_ID:
								begin
									state_nxt = ST_MEM_CMD;
									addr_ok_nxt = 1'b1;
								end
								CMD_FAST_SKIP:
								begin
									fast_nxt = 1'b1;
									state_nxt = ST_MEM_CMD;
									addr_ok_nxt = 1'b1;
								end
								CMD_FAST_MATCH:
								begin
									fast_nxt = 1'b1;
									state_nxt = ST_MATCH;
								end
								default: state_nxt = ST_DROP;
							endcase
						end
					end
				ST_READ:
					if (push_if.ready)
					begin
						cnt_nxt = cnt_r + 7'h01;
						if (cnt_r == LAST_ID_BIT)
						begin
							cnt_nxt = '0;
							state_nxt = ST_MEM_CMD;
							addr_ok_nxt = 1'b1;
						end
					end
				ST_MATCH:
					if (rx_valid)
					begin
						match_nxt = match_r && (rx_bit == id_bit);
						cnt_nxt = cnt_r + 7'h01;
						if (cnt_r == LAST_ID_BIT)
						begin
							cnt_nxt = '0;
							id_ok_nxt = crc_zero_next;
							if (match_nxt)
							begin
								state_nxt = ST_MEM_CMD;
								addr_ok_nxt = 1'b1;
							end
							else
								state_nxt = ST_DROP;
						end
					end
				ST_SRCH_TRUE:
					if (push_if.ready)
						state_nxt = ST_SRCH_COMP;
				ST_SRCH_COMP:
					if (push_if.ready)
						state_nxt = ST_SRCH_DIR;
				ST_SRCH_DIR:
					if (rx_valid)
					begin
						// A device whose bit differs from the chosen path leaves the search
						if (rx_bit != id_bit)
							state_nxt = ST_DROP;
						else if (cnt_r == LAST_ID_BIT)
						begin
							cnt_nxt = '0;
							state_nxt = ST_MEM_CMD;
							addr_ok_nxt = 1'b1;
						end
						else
						begin
							cnt_nxt = cnt_r + 7'h01;
							state_nxt = ST_SRCH_TRUE;
						end
					end
				ST_MEM_CMD:
					if (rx_valid)
					begin
						byte_nxt = rx_byte;
						cnt_nxt = cnt_r + 7'h01;
						if (cnt_r == LAST_BYTE_BIT)
						begin
							cnt_nxt = '0;
							mem_cmd_nxt = rx_byte;
							mem_v_nxt = 1'b1;
							state_nxt = ST_DONE;
						end
					end
				ST_IDLE, ST_DONE, ST_DROP:
					state_nxt = state_r;
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			byte_r <= '0;
			fast_r <= 1'b0;
			addr_ok_r <= 1'b0;
			match_r <= 1'b1;
			id_ok_r <= 1'b0;
			mem_v_r <= 1'b0;
			mem_cmd_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			byte_r <= byte_nxt;
			fast_r <= fast_nxt;
			addr_ok_r <= addr_ok_nxt;
			match_r <= match_nxt;
			id_ok_r <= id_ok_nxt;
			mem_v_r <= mem_v_nxt;
			mem_cmd_r <= mem_cmd_nxt;
		end
	end

	assign fast_mode = fast_r;
	assign addr_ok = addr_ok_r;
	assign id_check_ok = id_ok_r;
	assign mem_cmd_valid = mem_v_r;
	assign mem_cmd = mem_cmd_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_id_field_layout: assert property (ID_CODE[RANGE_LSB +: RANGE_W] == RANGE_CODE
		&& ID_CODE[SERIAL_LSB +: SERIAL_W] == SERIAL_NUM)
		else $error("identity field layout wrong");
	chk_id_check_field: assert property (crc8_of_prefix(ID_CODE[PREFIX_BITS-1:0])
		== ID_CODE[CHECK_LSB +: CHECK_W])
		else $error("check field does not cover prefix");
	chk_read_bit_order: assert property (state_r == ST_READ && push_if.ready
		|-> push_if.data == ID_CODE[cnt_r[5:0]])
		else $error("identity bit out of order");
	chk_cmd_lsb_first: assert property (rx_valid && state_r == ST_ADDR_CMD && !link_reset
		|=> byte_r[7] == $past(rx_bit))
		else $error("byte not assembled lsb first");
	chk_fast_after_cmd: assert property (state_r == ST_ADDR_CMD && rx_valid && !link_reset
		&& cnt_r == LAST_BYTE_BIT && (rx_byte == CMD_FAST_SKIP || rx_byte == CMD_FAST_MATCH)
		|=> fast_mode)
		else $error("fast mode not entered");
	chk_mem_needs_addr: assert property (mem_cmd_valid |-> $past(addr_ok_r, 1))
		else $error("memory command without address command");
	chk_match_check_zero: assert property (state_r == ST_MATCH && rx_valid && !link_reset
		&& cnt_r == LAST_ID_BIT && match_nxt |=> id_check_ok && crc_val == 8'h00)
		else $error("check register not zero after full code");
	chk_reset_clears_crc: assert property (link_reset |=> crc_val == 8'h00
		&& state_r == ST_ADDR_CMD && !addr_ok)
		else $error("link reset did not restart sequence");
	chk_flush_on_reset: assert property (link_reset |=> !tx_valid)
		else $error("send buffer kept bits across link reset");
endmodule

// ### testbench/link_master_model.sv
`timescale 1ns/1ps
module link_master_model (
	input wire logic clk_sys,
	input wire logic tx_valid,
	input wire logic tx_bit,
	output logic link_reset,
	output logic speed_reset,
	output logic rx_valid,
	output logic rx_bit,
	output logic tx_ready
);
	logic stall_en;
	int cyc;

	initial
	begin
		link_reset = 1'b0;
		speed_reset = 1'b0;
		rx_valid = 1'b0;
		rx_bit = 1'b0;
		tx_ready = 1'b0;
		stall_en = 1'b0;
		cyc = 0;
	end

	// ------------------------------------------------------------
	// Link start, then address command comes first
	// ------------------------------------------------------------
	task automatic link_init(input logic lr, input logic sp);
		@(negedge clk_sys);
		link_reset = lr;
		speed_reset = sp;
		@(negedge clk_sys);
		link_reset = 1'b0;
		speed_reset = 1'b0;
	endtask

	// ------------------------------------------------------------
	// Bit traffic
	// ------------------------------------------------------------
	task automatic send_bits(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk_sys);
			rx_valid = 1'b1;
			rx_bit = v[i];
		end
		@(negedge clk_sys);
		rx_valid = 1'b0;
		// Idle line shows the inverse so a stale bit is never trusted
		rx_bit = ~rx_bit;
	endtask

	// Stalls two cycles in three when stall_en is set
	task automatic get_bits(output logic [63:0] v, input int n);
		int k;
		k = 0;
		v = '0;
		while (k < n)
		begin
			@(negedge clk_sys);
			tx_ready = !stall_en || (cyc % 3 == 0);
			cyc++;
			// Sampled before the edge that pops it, never in the launch step
			if (tx_valid === 1'b1 && tx_ready)
			begin
				v[k] = tx_bit;
				k++;
			end
		end
		@(negedge clk_sys);
		tx_ready = 1'b0;
	endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rom_id_pkg::*;

	typedef struct packed {logic [7:0] cmd; logic alarm; logic addr; logic fast; logic txv;} row_s;

	logic clk_sys, reset, alarm_cond;
	logic link_reset, speed_reset, rx_valid, rx_bit, tx_valid, tx_ready, tx_bit;
	logic fast_mode, addr_ok, id_check_ok, mem_cmd_valid;
	logic [7:0] mem_cmd;
	logic [63:0] id_exp;
	int mismatches, num_checks, cycles;
	row_s rows [9] = '{
		'{CMD_READ_ID, 1'b0, 1'b0, 1'b0, 1'b1},
		'{CMD_MATCH_ID, 1'b0, 1'b0, 1'b0, 1'b0},
		'{CMD_SEARCH_ID, 1'b0, 1'b0, 1'b0, 1'b1},
		'{CMD_COND_SEARCH, 1'b0, 1'b0, 1'b0, 1'b0},
		'{CMD_COND_SEARCH, 1'b1, 1'b0, 1'b0, 1'b1},
		'{CMD_SKIP_ID, 1'b0, 1'b1, 1'b0, 1'b0},
		'{CMD_FAST_SKIP, 1'b0, 1'b1, 1'b1, 1'b0},
		'{CMD_FAST_MATCH, 1'b0, 1'b0, 1'b1, 1'b0},
		'{8'h3e, 1'b0, 1'b0, 1'b0, 1'b0}
	};

	rom_identity_crc_access #(
		.FAMILY_CODE(8'h3c), // Arbitrary value
		.SERIAL_NUM(36'h9abcdef01), // Arbitrary value
		.RANGE_CODE(12'h5a3) // Arbitrary value
	) i_rom_identity_crc_access (
		.clk_sys(clk_sys), .reset(reset), .link_reset(link_reset),
		.speed_reset(speed_reset), .rx_valid(rx_valid), .rx_bit(rx_bit),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit(tx_bit),
		.alarm_cond(alarm_cond), .fast_mode(fast_mode), .addr_ok(addr_ok),
		.id_check_ok(id_check_ok), .mem_cmd_valid(mem_cmd_valid), .mem_cmd(mem_cmd)
	);

	link_master_model i_link_master_model (
		.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_bit(tx_bit),
		.link_reset(link_reset), .speed_reset(speed_reset),
		.rx_valid(rx_valid), .rx_bit(rx_bit), .tx_ready(tx_ready)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] tb_crc(input logic [55:0] p);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
		begin
			fb = p[i] ^ c[0];
			c = {fb, c[7:1]} ^ {4'h0, fb, fb, 2'h0};
		end
		return c;
	endfunction

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Whole run is well under two thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [63:0] v;
		logic t, c;
		reset = 1'b1;
		alarm_cond = 1'b0;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
		id_exp[55:0] = {12'h5a3, 36'h9abcdef01, 8'h3c};
		id_exp[63:56] = tb_crc(id_exp[55:0]);
		repeat (20) @(negedge clk_sys);
		reset = 1'b0;
		settle(1);
		check("addr_ok_rst", addr_ok, 1'b0);
		check("fast_rst", fast_mode, 1'b0);
		check("txv_rst", tx_valid, 1'b0);
		// Memory byte with no address command is ignored
		i_link_master_model.send_bits(64'hc3, 8);
		settle(1);
		check("mem_idle", {mem_cmd_valid, mem_cmd}, 9'h000);

		foreach (rows[i])
		begin
			@(negedge clk_sys);
			alarm_cond = rows[i].alarm;
			i_link_master_model.link_init(1'b1, 1'b1);
			i_link_master_model.send_bits({56'h0, rows[i].cmd}, 8);
			settle(3);
			check("row_addr", addr_ok, rows[i].addr);
			check("row_fast", fast_mode, rows[i].fast);
			check("row_txv", tx_valid, rows[i].txv);
		end

		// Read with a stalling receiver
		i_link_master_model.stall_en = 1'b1;
		i_link_master_model.link_init(1'b1, 1'b1);
		i_link_master_model.send_bits({56'h0, CMD_READ_ID}, 8);
		i_link_master_model.get_bits(v, 64);
		check("read_id", v, id_exp);
		settle(3);
		check("read_addr", addr_ok, 1'b1);

		// Search, true and complement per bit
		i_link_master_model.link_init(1'b1, 1'b0);
		i_link_master_model.send_bits({56'h0, CMD_SEARCH_ID}, 8);
		for (int i = 0; i < 64; i++)
		begin
			i_link_master_model.get_bits(v, 1);
			t = v[0];
			i_link_master_model.get_bits(v, 1);
			c = v[0];
			check("search_pair", {t, c}, {id_exp[i], ~id_exp[i]});
			i_link_master_model.send_bits({63'h0, id_exp[i]}, 1);
		end
		settle(3);
		check("search_addr", addr_ok, 1'b1);

		// Good match then memory byte, one-cycle pulse
		i_link_master_model.link_init(1'b1, 1'b0);
		i_link_master_model.send_bits({56'h0, CMD_MATCH_ID}, 8);
		i_link_master_model.send_bits(id_exp, 64);
		settle(1);
		check("match_ok", {addr_ok, id_check_ok}, 2'b11);
		i_link_master_model.send_bits(64'ha5, 8);
		check("mem_pulse", {mem_cmd_valid, mem_cmd}, 9'h1a5);
		settle(1);
		check("mem_end", mem_cmd_valid, 1'b0);

		// Corrupt check byte: match refused, memory byte ignored
		i_link_master_model.link_init(1'b1, 1'b0);
		i_link_master_model.send_bits({56'h0, CMD_MATCH_ID}, 8);
		i_link_master_model.send_bits(id_exp ^ 64'h0100_0000_0000_0000, 64);
		settle(1);
		check("match_bad", {addr_ok, id_check_ok}, 2'b00);
		i_link_master_model.send_bits(64'h5a, 8);
		check("mem_refused", mem_cmd_valid, 1'b0);

		// Fast match, then speed reset alone leaves fast mode
		i_link_master_model.link_init(1'b1, 1'b0);
		i_link_master_model.send_bits({56'h0, CMD_FAST_MATCH}, 8);
		settle(2);
		check("fast_on", fast_mode, 1'b1);
		i_link_master_model.send_bits(id_exp, 64);
		settle(1);
		check("fast_match", {addr_ok, fast_mode}, 2'b11);
		i_link_master_model.link_init(1'b0, 1'b1);
		settle(1);
		check("fast_off", fast_mode, 1'b0);

		// Reset in mid-run drops access
		i_link_master_model.link_init(1'b1, 1'b0);
		i_link_master_model.send_bits({56'h0, CMD_SKIP_ID}, 8);
		@(negedge clk_sys);
		reset = 1'b1;
		@(negedge clk_sys);
		reset = 1'b0;
		settle(1);
		check("addr_reset", addr_ok, 1'b0);
		give_verdict();
	end
endmodule
